// file: core/hcd_channel.v
// Notes on behaviour
// R1 - Stuff zeros only inside frames, never transparent.
// R2 - Idle fill byte is 7Eh or FFh.
// R3 - One to sixteen flags between packets.
// R4 - Append CRC-16, CRC-32 or no FCS.
// R5 - Transmit inversion applies to every outgoing bit.
// R6 - Transmit LSB first, or MSB first flipped.
// R7 - Transparent transmit: raw bytes, no flags, FCS.
// R8 - FCS inversion complements the generated check sequence.
// R9 - Eight-bit select addresses channels 1 to 256; the code addresses channels 0 to 255.
// R10 - Direction one fetches definition, busy until done.
// R11 - Direction zero stores definition, busy until done.
// R12 - Host waits for busy low before access.
// R13 - Transparent receive skips all HDLC processing.
// R14 - Software avoids end-of-packet-only descriptors there.
// R15 - Overlong packet aborted when length check enabled.
// R16 - CRC select: none, 16, 32, illegal.
// R17 - Receive inversion before processing, stored inverted.
// R18 - Bit flip puts first bit in MSB.
// R19 - FCS strip withholds FCS from host data.
// R20 - Seven ones abort unless abort check disabled.
// R21 - Destuffing removed when destuff disable set.
// R22 - Keep 256 definition words, bit 9 stored.
`include "hcd_defs.vh"
`default_nettype none

module hcd_channel
(
	// Clock, reset and enable
	input  wire        mclk,
	input  wire        reset,
	input  wire        ce,
	// Register port
	input  wire [11:0] reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// Transmit byte source
	input  wire [7:0]  tx_data,
	input  wire        tx_valid,
	input  wire        tx_last,
	output reg         tx_take,
	// Transmit serial side
	input  wire        tx_tick,
	output reg         tx_bit,
	// Receive serial side
	input  wire        rx_tick,
	input  wire        rx_bit,
	input  wire [7:0]  rx_chan,
	// Receive byte sink
	output reg  [7:0]  rx_byte,
	output reg         rx_byte_valid,
	output reg         rx_eof,
	output reg         rx_crc_err,
	output reg         rx_bad_bits,
	output reg         rx_abort,
	output reg         rx_too_long
);

	localparam [4:0] S_FILL  = 5'h01;
	localparam [4:0] S_OPEN  = 5'h02;
	localparam [4:0] S_DATA  = 5'h04;
	localparam [4:0] S_FCS   = 5'h08;
	localparam [4:0] S_CLOSE = 5'h10;

	function [31:0] crc_bit;
		input [31:0] c;
		input        b;
		input        wide;
		begin
			if (c[0] ^ b)
				crc_bit = (c >> 1) ^ (wide ? `HCD_POLY32 : `HCD_POLY16);
			else
				crc_bit = c >> 1;
		end
	endfunction

	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0]  d;
		input        wide;
		integer i;
		reg [31:0] t;
		begin
			t = c;
			for (i = 0; i < 8; i = i + 1)
				t = crc_bit(t, d[i], wide);
			crc_byte = t;
		end
	endfunction

	function [7:0] rev8;
		input [7:0] d;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				rev8[i] = d[7 - i];
		end
	endfunction

	// Indirect definition store and host registers.
	reg [`HCD_RX_DEF_W-1:0] def_ram [0:255];
	reg [7:0]               chan_sel;
	reg                     ia_dir;
	reg                     ia_busy;
	reg [`HCD_RX_DEF_W-1:0] def_word;
	reg [`HCD_TX_CFG_W-1:0] tx_cfg;
	reg [15:0]              rx_maxlen;
	reg [`HCD_RX_DEF_W-1:0] rcfg;

	wire sel_hit = reg_addr == `HCD_ADDR_SELECT;
	wire def_hit = reg_addr == `HCD_ADDR_DEFINITION;

	always @(posedge mclk)
	begin
		if (ce && ia_busy && ia_dir != `HCD_DIR_READ)
			def_ram[chan_sel] <= def_word; // R11 R22
	end

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			chan_sel  <= 8'h00;
			ia_dir    <= 1'b0;
			ia_busy   <= 1'b0;
			def_word  <= `HCD_RST_DEF;
			tx_cfg    <= `HCD_RST_TX_CFG;
			rx_maxlen <= `HCD_RST_MAXLEN;
			reg_rdata <= 16'h0000;
			rcfg      <= `HCD_RST_DEF;
		end
		else if (ce)
		begin
			rcfg <= def_ram[rx_chan];
			// Busy lasts one cycle: the RAM answers in a single access.
			if (ia_busy)
			begin
				ia_busy <= 1'b0; // R10 R11
				if (ia_dir == `HCD_DIR_READ)
					def_word <= def_ram[chan_sel]; // R10
			end
			else if (reg_wr && sel_hit)
			begin
				chan_sel <= reg_wdata[7:0]; // R9
				ia_dir   <= reg_wdata[`HCD_SEL_DIR_BIT];
				ia_busy  <= 1'b1; // R10 R11
			end
			// A definition write during a store or fetch (busy) would race the RAM, so it is ignored.
			if (reg_wr && def_hit && !ia_busy)
				def_word <= reg_wdata[`HCD_RX_DEF_W-1:0]; // R22
			if (reg_wr && reg_addr == `HCD_ADDR_TX_CONFIG)
				tx_cfg <= reg_wdata[`HCD_TX_CFG_W-1:0];
			if (reg_wr && reg_addr == `HCD_ADDR_RX_MAXLEN)
				rx_maxlen <= reg_wdata;
			if (reg_rd && sel_hit)
				reg_rdata <= {ia_busy, ia_dir, 6'h00, chan_sel};
			else if (reg_rd && def_hit)
				reg_rdata <= {6'h00, def_word};
			else if (reg_rd && reg_addr == `HCD_ADDR_TX_CONFIG)
				reg_rdata <= {4'h0, tx_cfg};
			else if (reg_rd && reg_addr == `HCD_ADDR_RX_MAXLEN)
				reg_rdata <= rx_maxlen;
			else
				reg_rdata <= 16'h0000;
		end
	end

	// Transmit framer.
	wire       t_trans  = tx_cfg[`HCD_TX_TRANS_BIT];
	wire [1:0] t_crcsel = t_trans ? `HCD_CRC_NONE : tx_cfg[`HCD_TX_CRC_LO+1:`HCD_TX_CRC_LO]; // R4
	wire       t_wide   = t_crcsel == `HCD_CRC_32;
	wire       t_crc_on = t_crcsel == `HCD_CRC_16 || t_wide;
	wire [3:0] t_nflag  = tx_cfg[`HCD_TX_FLAGS_LO+3:`HCD_TX_FLAGS_LO];
	wire [7:0] t_fill   = tx_cfg[`HCD_TX_FILL_BIT] ? `HCD_FILL_ONES : `HCD_FLAG_BYTE; // R2
	wire [7:0] t_data_w = tx_cfg[`HCD_TX_FLIP_BIT] ? rev8(tx_data) : tx_data; // R6

	reg [4:0]  tstate;
	reg [7:0]  tsh;
	reg [2:0]  tbit;
	reg [2:0]  tones;
	reg [31:0] tcrc;
	reg [3:0]  tflags;
	reg [1:0]  tfcsn;
	reg        tlast;
	reg [4:0]  next_tstate;
	reg [7:0]  next_tsh;
	reg [3:0]  next_tflags;
	reg [1:0]  next_tfcsn;
	reg        take;

	always @*
	begin
		next_tstate = tstate;
		next_tsh    = t_fill;
		next_tflags = tflags;
		next_tfcsn  = tfcsn;
		take        = 1'b0;
		case (tstate)
			S_FILL:
				if (tx_valid && t_trans)
				begin
					take        = 1'b1; // R7
					next_tstate = S_DATA;
				end
				else if (tx_valid)
				begin
					next_tstate = S_OPEN;
					next_tsh    = `HCD_FLAG_BYTE;
					next_tflags = t_nflag; // R3
				end
			S_OPEN:
				if (tflags != 4'h0)
				begin
					next_tflags = tflags - 4'h1; // R3
					next_tsh    = `HCD_FLAG_BYTE;
				end
				else if (tx_valid)
				begin
					take        = 1'b1;
					next_tstate = S_DATA;
				end
				else
				begin
					next_tstate = S_FILL;
					next_tsh    = t_fill; // R2
				end
			S_DATA:
				if (tlast && !t_trans)
				begin
					next_tstate = t_crc_on ? S_FCS : S_CLOSE; // R4
					next_tsh    = `HCD_FLAG_BYTE;
					next_tfcsn  = t_wide ? 2'h3 : 2'h1;
				end
				else if (tx_valid)
					take = 1'b1;
				else
				begin
					// Underrun sends eight ones as an abort, except transparent.
					next_tstate = S_FILL;
					next_tsh    = t_trans ? t_fill : `HCD_FILL_ONES;
				end
			S_FCS:
				if (tfcsn == 2'h0)
				begin
					next_tstate = S_CLOSE;
					next_tsh    = `HCD_FLAG_BYTE;
				end
				else
					next_tfcsn = tfcsn - 2'h1;
			S_CLOSE:
				if (tx_valid && t_nflag == 4'h0)
				begin
					take        = 1'b1; // R3
					next_tstate = S_DATA;
				end
				else if (tx_valid)
				begin
					next_tstate = S_OPEN;
					next_tsh    = `HCD_FLAG_BYTE;
					next_tflags = t_nflag - 4'h1; // R3
				end
				else
					next_tstate = S_FILL; // R2
			default:
				next_tstate = S_FILL;
		endcase
		if (take)
			next_tsh = t_data_w;
	end

	wire t_stuff_zone = (tstate == S_DATA || tstate == S_FCS) && !t_trans;
	// Five trailing ones of the frame still need their zero before the closing flag.
	wire t_stuff      = (t_stuff_zone || tstate == S_CLOSE) && !t_trans && tones == 3'd5; // R1
	wire t_out = (tstate == S_FCS) ? (~tcrc[0] ^ tx_cfg[`HCD_TX_FCSINV_BIT]) : tsh[0]; // R8

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			tstate  <= S_FILL;
			tsh     <= `HCD_FLAG_BYTE;
			tbit    <= 3'd0;
			tones   <= 3'd0;
			tcrc    <= `HCD_INIT32;
			tflags  <= 4'h0;
			tfcsn   <= 2'h0;
			tlast   <= 1'b0;
			tx_bit  <= 1'b0;
			tx_take <= 1'b0;
		end
		else if (ce)
		begin
			tx_take <= 1'b0;
			if (tx_tick && t_stuff)
			begin
				tx_bit <= tx_cfg[`HCD_TX_INV_BIT]; // R1 R5
				tones  <= 3'd0;
			end
			else if (tx_tick)
			begin
				tx_bit <= t_out ^ tx_cfg[`HCD_TX_INV_BIT]; // R5
				tones  <= (!t_out || !t_stuff_zone) ? 3'd0 : (tones == 3'd7 ? tones : tones + 3'd1);
				tbit   <= tbit + 3'd1;
				if (tstate == S_FCS)
					tcrc <= tcrc >> 1;
				tsh <= tsh >> 1; // R6
				if (tbit == 3'd7)
				begin
					tstate  <= next_tstate;
					tsh     <= next_tsh;
					tflags  <= next_tflags;
					tfcsn   <= next_tfcsn;
					tx_take <= take;
					if (take)
					begin
						tlast <= tx_last;
						if (tstate != S_DATA)
							tcrc <= crc_byte(t_wide ? `HCD_INIT32 : `HCD_INIT16, next_tsh, t_wide);
						else
							tcrc <= crc_byte(tcrc, next_tsh, t_wide); // R4
					end
				end
			end
		end
	end

	// Receive deframer.
	wire       r_trans  = rcfg[`HCD_RX_TRANS_BIT];
	wire [1:0] r_crcsel = rcfg[`HCD_RX_CRC_HI:`HCD_RX_CRC_LO];
	wire       r_wide   = r_crcsel == `HCD_CRC_32; // R16
	wire       r_crc_on = r_crcsel == `HCD_CRC_16 || r_wide; // R16
	wire [2:0] r_strip_n = (rcfg[`HCD_RX_STRIP_BIT] && r_crc_on) ? (r_wide ? 3'd4 : 3'd2)
		: 3'd0; // R19
	wire       r_b      = rx_bit ^ rcfg[`HCD_RX_INV_BIT]; // R17

	reg [7:0]  rsh;
	reg [2:0]  rbit;
	reg [2:0]  rones;
	reg        rin;
	reg [16:0] rcount;
	reg [31:0] rcrc;
	reg [31:0] rdly;
	reg [2:0]  rheld;

	wire       r_flag    = rones == 3'd6 && !r_b; // R13
	wire       r_abort   = !rcfg[`HCD_RX_ABTD_BIT] && rones == 3'd6 && r_b; // R20
	wire       r_stuffed = !rcfg[`HCD_RX_ZDD_BIT] && rones == 3'd5 && !r_b; // R21
	wire [7:0] r_new     = {r_b, rsh[7:1]};
	wire [31:0] r_good   = r_wide ? `HCD_GOOD32 : `HCD_GOOD16;
	wire       r_long    = rcfg[`HCD_RX_LEN_BIT] && (rcount + 17'd1) > {1'b0, rx_maxlen};
	reg  [7:0] r_emit;

	always @*
	begin
		case (r_strip_n)
			3'd2:    r_emit = rdly[15:8];
			3'd4:    r_emit = rdly[31:24];
			default: r_emit = r_new;
		endcase
	end

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			rsh           <= 8'h00;
			rbit          <= 3'd0;
			rones         <= 3'd0;
			rin           <= 1'b0;
			rcount        <= 17'd0;
			rcrc          <= `HCD_INIT32;
			rdly          <= 32'h00000000;
			rheld         <= 3'd0;
			rx_byte       <= 8'h00;
			rx_byte_valid <= 1'b0;
			rx_eof        <= 1'b0;
			rx_crc_err    <= 1'b0;
			rx_bad_bits   <= 1'b0;
			rx_abort      <= 1'b0;
			rx_too_long   <= 1'b0;
		end
		else if (ce)
		begin
			rx_byte_valid <= 1'b0;
			rx_eof        <= 1'b0;
			rx_crc_err    <= 1'b0;
			rx_bad_bits   <= 1'b0;
			rx_abort      <= 1'b0;
			rx_too_long   <= 1'b0;
			if (rx_tick && r_trans)
			begin
				// No end of packet ever appears here; bytes just flow.
				rsh  <= r_new; // R13
				rbit <= rbit + 3'd1;
				rin  <= 1'b0;
				if (rbit == 3'd7)
				begin
					rx_byte       <= rcfg[`HCD_RX_FLIP_BIT] ? rev8(r_new) : r_new; // R18
					rx_byte_valid <= 1'b1;
				end
			end
			else if (rx_tick)
			begin
				rones <= !r_b ? 3'd0 : (rones == 3'd7 ? rones : rones + 3'd1);
				if (r_flag)
				begin
					if (rin && rcount != 17'd0)
					begin
						rx_eof      <= 1'b1;
						rx_crc_err  <= r_crc_on && rcrc != r_good; // R16
						rx_bad_bits <= rbit != 3'd7;
					end
					rin    <= 1'b1;
					rbit   <= 3'd0;
					rcount <= 17'd0;
					rheld  <= 3'd0;
					rcrc   <= r_wide ? `HCD_INIT32 : `HCD_INIT16;
				end
				else if (r_abort)
				begin
					rx_abort <= rin; // R20
					rin      <= 1'b0;
				end
				else if (!r_stuffed && rin) // R21
				begin
					rsh  <= r_new;
					rbit <= rbit + 3'd1;
					if (rbit == 3'd7 && r_long)
					begin
						rx_too_long <= 1'b1; // R15
						rin         <= 1'b0;
					end
					else if (rbit == 3'd7)
					begin
						rcount <= rcount + 17'd1;
						rcrc   <= crc_byte(rcrc, r_new, r_wide);
						rdly   <= {rdly[23:0], r_new};
						rheld  <= (rheld == 3'd4) ? rheld : rheld + 3'd1;
						// Stripping holds bytes back until they cannot be FCS.
						if (rheld >= r_strip_n)
						begin
							rx_byte       <= rcfg[`HCD_RX_FLIP_BIT] ? rev8(r_emit) : r_emit; // R18 R19
							rx_byte_valid <= 1'b1;
						end
					end
				end
			end
		end
	end

endmodule // hcd_channel

`default_nettype wire

// file: core/hcd_defs.vh
`ifndef HCD_DEFS_VH
`define HCD_DEFS_VH

// Register byte addresses.
`define HCD_ADDR_SELECT     12'h400
`define HCD_ADDR_DEFINITION 12'h404
`define HCD_ADDR_TX_CONFIG  12'h408
`define HCD_ADDR_RX_MAXLEN  12'h40c

// Channel indirect select fields.
`define HCD_SEL_BUSY_BIT    15
`define HCD_SEL_DIR_BIT     14
`define HCD_DIR_READ        1'b1

// Receive channel definition fields.
`define HCD_RX_TRANS_BIT    0
`define HCD_RX_LEN_BIT      1
`define HCD_RX_CRC_LO       2
`define HCD_RX_CRC_HI       3
`define HCD_RX_INV_BIT      4
`define HCD_RX_FLIP_BIT     5
`define HCD_RX_STRIP_BIT    6
`define HCD_RX_ABTD_BIT     7
`define HCD_RX_ZDD_BIT      8
`define HCD_RX_DEF_W        10

// Transmit configuration fields.
`define HCD_TX_TRANS_BIT    0
`define HCD_TX_FILL_BIT     1
`define HCD_TX_CRC_LO       2
`define HCD_TX_INV_BIT      4
`define HCD_TX_FLIP_BIT     5
`define HCD_TX_FCSINV_BIT   6
`define HCD_TX_FLAGS_LO     8
`define HCD_TX_CFG_W        12

// Reset values.
`define HCD_RST_DEF         10'h000
`define HCD_RST_TX_CFG      12'h000
`define HCD_RST_MAXLEN      16'hffff

// Framing constants.
`define HCD_CRC_NONE        2'b00
`define HCD_CRC_16          2'b01
`define HCD_CRC_32          2'b10
`define HCD_FLAG_BYTE       8'h7e
`define HCD_FILL_ONES       8'hff
`define HCD_POLY16          32'h00008408
`define HCD_POLY32          32'hedb88320
`define HCD_INIT16          32'h0000ffff
`define HCD_INIT32          32'hffffffff
`define HCD_GOOD16          32'h0000f0b8
`define HCD_GOOD32          32'hdebb20e3

`endif

// file: testbench/hcd_channel_checker.sv
`default_nettype none

module hcd_channel_checker
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        ce,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Serial and byte sides
	input wire logic        tx_valid,
	input wire logic        tx_take,
	input wire logic        tx_tick,
	input wire logic        tx_bit,
	input wire logic        rx_tick,
	input wire logic        rx_byte_valid,
	input wire logic        rx_eof
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sel_wr;
	logic sel_rd;
	assign sel_wr = ce && reg_wr && reg_addr == 12'h400;
	assign sel_rd = ce && reg_rd && reg_addr == 12'h400;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);

	chk_read_idle_zero: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	chk_busy_set_one: assert property (sel_wr ##1 sel_rd |=> reg_rdata[15] == 1'b1)
		else $error("busy not set right after select write");
	chk_busy_clears: assert property (sel_wr ##1 sel_rd ##1 sel_rd |=> reg_rdata[15] == 1'b0)
		else $error("busy still set two cycles after select write");
	chk_def_upper_zero: assert property (ce && reg_rd && reg_addr == 12'h404
		|=> reg_rdata[15:10] == 6'h00)
		else $error("definition upper bits not zero");
	chk_sel_gap_zero: assert property (sel_rd |=> reg_rdata[13:8] == 6'h00)
		else $error("select unused bits not zero");
	chk_take_octet: assert property (tx_take |-> $past(tx_tick) && $past(tx_valid)
		##1 !tx_take [*7])
		else $error("byte taken without tick or too soon");
	chk_bit_on_tick: assert property (!tx_tick |=> $stable(tx_bit))
		else $error("serial bit moved without tick");
	chk_rx_byte_gap: assert property (rx_byte_valid |-> $past(rx_tick)
		##1 !rx_byte_valid [*7])
		else $error("received byte not on an octet");
	chk_eof_on_tick: assert property (rx_eof |-> $past(rx_tick) && !rx_byte_valid)
		else $error("end of frame not after a bit");
endmodule // hcd_channel_checker

bind hcd_channel hcd_channel_checker hcd_channel_checker_inst
(
	.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_take(tx_take),
	.tx_tick(tx_tick), .tx_bit(tx_bit), .rx_tick(rx_tick),
	.rx_byte_valid(rx_byte_valid), .rx_eof(rx_eof)
);

`default_nettype wire

// file: testbench/hcd_serial_model.sv
`default_nettype none

// Line side in loopback: the received stream is the sent one, one bit late.
module hcd_serial_model
#(
	parameter int DIV = 4
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Serial lines
	input wire logic tx_bit,
	output var logic tx_tick,
	output var logic rx_tick,
	output var logic rx_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= 4'h0;
			tx_tick <= 1'b0;
			rx_tick <= 1'b0;
			rx_bit <= 1'b1;
		end
		else
		begin
			cnt <= (cnt == DIV - 1) ? 4'h0 : cnt + 4'h1;
			tx_tick <= cnt == 4'h0;
			rx_tick <= tx_tick;
			if (tx_tick)
				rx_bit <= tx_bit;
		end
	end
endmodule // hcd_serial_model

`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk      = 1'b0;
	logic        reset     = 1'b1;
	logic        ce        = 1'b1;
	logic [11:0] reg_addr  = 12'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [7:0]  tx_data   = 8'h00;
	logic        tx_valid  = 1'b0;
	logic        tx_last   = 1'b0;
	logic [7:0]  rx_chan   = 8'h05;
	wire  [15:0] reg_rdata;
	wire  [7:0]  rx_byte;
	wire         tx_take, tx_tick, tx_bit, rx_tick, rx_bit, rx_byte_valid;
	wire         rx_eof, rx_crc_err, rx_bad_bits, rx_abort, rx_too_long;
	int          err_count = 0, compares = 0, cyc = 0, eof_n, crc_n, ab_n, tl_n, bb_n, fk;
	logic [7:0]  rxq[$];
	logic [15:0] q;

	hcd_channel hcd_channel_inst
	(
		.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_take(tx_take), .tx_tick(tx_tick),
		.tx_bit(tx_bit), .rx_tick(rx_tick), .rx_bit(rx_bit), .rx_chan(rx_chan),
		.rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_eof(rx_eof),
		.rx_crc_err(rx_crc_err), .rx_bad_bits(rx_bad_bits), .rx_abort(rx_abort),
		.rx_too_long(rx_too_long)
	);
	hcd_serial_model hcd_serial_model_inst
	(
		.mclk(mclk), .reset(reset), .tx_bit(tx_bit), .tx_tick(tx_tick),
		.rx_tick(rx_tick), .rx_bit(rx_bit)
	);

	always #2.5 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cyc++;
		if (rx_byte_valid === 1'b1)
			rxq.push_back(rx_byte);
		eof_n += (rx_eof === 1'b1);
		crc_n += (rx_crc_err === 1'b1);
		ab_n += (rx_abort === 1'b1);
		tl_n += (rx_too_long === 1'b1);
		bb_n += (rx_bad_bits === 1'b1);
		if (cyc == 40000)
		begin
			err_count++;
			wrap_up;
		end
	end

	function automatic logic [7:0] rev(input logic [7:0] x);
		for (int i = 0; i < 8; i++)
			rev[i] = x[7 - i];
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Entered just after a rising edge; leaves a gap cycle so strobes never re-rise at once.
	task bus(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [15:0] r);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
		r = reg_rdata;
	endtask

	task rdc(input logic [11:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000, q);
		chk($sformatf("register %h", a), e, q);
	endtask

	task store(input logic [7:0] ch, input logic [15:0] w);
		int k;
		bus(1'b1, 12'h404, w, q);
		bus(1'b1, 12'h400, {8'h00, ch}, q);
		k = 0;
		do
		begin
			bus(1'b0, 12'h400, 16'h0000, q);
			k++;
		end
		while (q[15] !== 1'b0 && k < 8);
		chk("busy after store", 0, q[15]);
	endtask

	// Reads the select twice back to back right behind the write to see busy rise and fall.
	task fetch(input logic [7:0] ch, input logic [15:0] e);
		logic [15:0] b1;
		reg_addr <= 12'h400;
		reg_wdata <= {8'h40, ch};
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		@(posedge mclk);
		reg_rd <= 1'b0;
		b1 = reg_rdata;
		@(posedge mclk);
		chk("busy in fetch", 1, b1[15]);
		chk("select after fetch", {8'h40, ch}, reg_rdata);
		rdc(12'h404, e);
	endtask

	task clr;
		@(negedge mclk);
		rxq.delete();
		eof_n = 0;
		crc_n = 0;
		ab_n = 0;
		tl_n = 0;
		bb_n = 0;
		@(posedge mclk);
	endtask

	task send(input int n, input logic [31:0] b, input logic lst);
		int k;
		for (int i = 0; i < n; i++)
		begin
			tx_data <= b[8*i +: 8];
			tx_valid <= 1'b1;
			tx_last <= lst && i == n - 1;
			k = 0;
			do
			begin
				@(posedge mclk);
				k++;
			end
			while (tx_take !== 1'b1 && k < 1000);
			chk("byte taken", 1, tx_take);
			if (i == 0)
				fk = k;
		end
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
	endtask

	task prep(input logic [11:0] tc, input logic [15:0] d);
		store(8'h05, d);
		bus(1'b1, 12'h408, {4'h0, tc}, q);
		repeat (100) @(posedge mclk);
		clr;
	endtask

	// The data holds a flag pattern and a run of ten ones, so stuffing is needed.
	task frame(input logic [11:0] tc, input logic [15:0] d, input logic fl, input logic e);
		logic [7:0] x;
		prep(tc, d);
		send(3, 32'h001ff87e, 1'b1);
		for (int i = 0; i < 600 && eof_n == 0; i++)
			@(posedge mclk);
		chk("end of frame", 1, eof_n);
		chk("byte count", 3, rxq.size());
		foreach (rxq[i])
		begin
			x = 8'(24'h1ff87e >> (8 * i));
			chk("received byte", fl ? rev(x) : x, rxq[i]);
		end
		chk("crc error", e, crc_n);
		chk("bad bit count", 0, bb_n);
		// From idle the first byte waits one fill byte at most, then 32 cycles per flag.
		chk("opening flags", tc[11:8] + 1, (fk - 2) / 32);
	endtask

	task bad(input logic [15:0] d, input int n, input logic lst, input logic [1:0] e);
		prep(12'h004, d);
		send(n, 32'h001ff87e, lst);
		repeat (400) @(posedge mclk);
		chk("abort and too long", e, {ab_n != 0, tl_n != 0});
	endtask

	task fill(input logic [11:0] c, input int e);
		int n;
		bus(1'b1, 12'h408, {4'h0, c}, q);
		repeat (100) @(posedge mclk);
		n = 0;
		repeat (16)
		begin
			do
				@(posedge mclk);
			while (rx_tick !== 1'b1);
			n += rx_bit;
		end
		chk("ones on idle line", e, n);
	endtask

	// Three stuffed zeros in the data plus up to three in the FCS stay in: never a whole octet.
	task nodestuff;
		prep(12'h004, 16'h0104);
		send(3, 32'h001ff87e, 1'b1);
		repeat (400) @(posedge mclk);
		chk("end of frame", 1, eof_n);
		chk("bad bit count", 1, bb_n);
	endtask

	// Both sides transparent with 7Eh fill: no packet may end, raw zeros still arrive.
	task rxtr;
		int z;
		prep(12'h001, 16'h0001);
		send(2, 32'h00000000, 1'b0);
		repeat (200) @(posedge mclk);
		z = 0;
		foreach (rxq[i])
			z += (rxq[i] === 8'h00);
		chk("end of frame in transparent", 0, eof_n);
		chk("zero bytes passed", 1, z != 0);
	endtask

	task wrap_up;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rdc(12'h400, 16'h0000);
		rdc(12'h404, 16'h0000);
		rdc(12'h408, 16'h0000);
		rdc(12'h40c, 16'hffff);
		rdc(12'h7fc, 16'h0000);
		bus(1'b1, 12'h404, 16'hffff, q);
		rdc(12'h404, 16'h03ff);
		store(8'hff, 16'h02a5);
		store(8'h00, 16'h015a);
		bus(1'b1, 12'h404, 16'h0000, q);
		fetch(8'hff, 16'h02a5);
		fetch(8'h00, 16'h015a);
		frame(12'h004, 16'h0044, 1'b0, 1'b0);
		frame(12'h008, 16'h0048, 1'b0, 1'b0);
		frame(12'h000, 16'h0040, 1'b0, 1'b0);
		frame(12'h044, 16'h0044, 1'b0, 1'b1);
		frame(12'h014, 16'h0054, 1'b0, 1'b0);
		frame(12'h020, 16'h0040, 1'b1, 1'b0);
		frame(12'h000, 16'h0060, 1'b1, 1'b0);
		frame(12'hf04, 16'h0244, 1'b0, 1'b0);
		bus(1'b1, 12'h40c, 16'h0001, q);
		bad(16'h0044, 1, 1'b0, 2'b10);
		bad(16'h00c4, 1, 1'b0, 2'b00);
		bad(16'h0046, 3, 1'b1, 2'b01);
		bad(16'h0044, 3, 1'b1, 2'b00);
		nodestuff;
		rxtr;
		fill(12'h000, 12);
		fill(12'h002, 16);
		fill(12'h003, 16);
		fill(12'h011, 4);
		wrap_up;
	end
endmodule // tb_top

`default_nettype wire
